// ==== ambient_light_register_map.sv ====
// Light sensor register bank behind a two-wire serial slave
//
// How it works
// - Every register is sixteen bits wide.
// - Pointer 00h is result, 01h control, 02h lower, 03h upper.
// - Read-only maker and part identification sit at 7Eh and 7Fh.
// - Settings and results are reached over the serial bus; range select also drives range_sel.
// - Result holds the latest finished conversion; writes leave it alone.
// - Result exponent in 15:12, mantissa in 11:0, both reset zero.
// - Mantissa is unsigned binary from zero to range full scale.
// - One mantissa step weighs 0.01 lux times two to the exponent.
// - Mask enabled with a manual range forces the result exponent to zero.
// - A control write aborts a running conversion at once.
// - After a control write a new conversion starts if mode asks.
// - Control holds nine fields from range select down to fault count.
// - Range code 1100b picks the range itself and reports it.
// - Range select shares the exponent format and resets to automatic.
// - The pointer is kept so repeated reads hit the same register.
// - Reading the control register clears the conversion ready flag.
// - Mode 00 shuts down, 01 converts once, 1x converts continuously.
`timescale 1ns/1ps
`include "light_map.svh"
module ambient_light_register_map
	import light_pkg::*;
#(
	parameter logic [6:0]  DEV_ADDR  = 7'h2a,    // Arbitrary bus address
	parameter logic [15:0] MAKER_ID  = 16'h5a5a, // Arbitrary value
	parameter logic [15:0] PART_ID   = 16'ha5a5, // Arbitrary value
	parameter int unsigned SHORT_CYC = `CONV_SHORT_MS * `CLK_KHZ,
	parameter int unsigned LONG_CYC  = `CONV_LONG_MS * `CLK_KHZ
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	input  wire logic [11:0] fe_mantissa,
	input  wire logic [3:0]  fe_exponent,
	input  wire logic        fe_overflow,
	output logic             sda_o,
	output logic             sda_oe,
	output logic             converting,
	output logic [3:0]       range_sel
);
	localparam logic [15:0] CTL_RST = `RST_CONTROL;

	bank_state_t q;
	bank_state_t d;
	logic        rise;
	logic        fall;
	logic        sta;
	logic        stp;
	logic        bit_in;
	logic        ptr_load;
	logic        wr_commit;
	logic        cfg_wr;
	logic        rd_cfg;
	logic        conv_start;
	logic        conv_stop;
	logic        conv_done;
	logic [15:0] wdat;
	logic [15:0] word;
	logic [7:0]  nbyte;
	logic [3:0]  exp_now;

	////////////////////////////////////////////////////////////////////////////////
	// Register read decode

	// Word seen by the host at the current pointer
	function automatic logic [15:0] rd_word(input bank_state_t s);
		logic [15:0] w;
		w = 16'h0000;
		unique case (s.ptr)
			`OFS_RESULT:  w = s.res;
			`OFS_CONTROL: w = {s.fsel, s.clen, s.mode, s.over, s.ready, 2'h0,
			                   s.latch, s.sense, s.mask, s.faults};
			`OFS_LOWER:   w = s.lo_lim;
			`OFS_UPPER:   w = s.hi_lim;
			`OFS_MAKER:   w = MAKER_ID;
			`OFS_PART:    w = PART_ID;
			default:      w = 16'h0000;
		endcase
		return w;
	endfunction : rd_word

	////////////////////////////////////////////////////////////////////////////////
	// Conversion timer

	light_conv #(
		.SHORT_CYC (SHORT_CYC),
		.LONG_CYC  (LONG_CYC)
	) u_conv (
		.clk      (clk),
		.rst_b    (rst_b),
		.start    (conv_start),
		.stop     (conv_stop),
		.long_sel (d.clen),
		.busy     (converting),
		.done     (conv_done)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	// Pin edges from the synchronised copies
	always_comb begin
		rise   = q.scl[1] & ~q.scl[2];
		fall   = ~q.scl[1] & q.scl[2];
		sta    = q.scl[1] & q.scl[2] & q.sda[2] & ~q.sda[1];
		stp    = q.scl[1] & q.scl[2] & ~q.sda[2] & q.sda[1];
		bit_in = q.sda[1];
		word   = rd_word(q);
		nbyte  = q.lo ? word[7:0] : word[15:8];
		wdat   = {q.whi, q.sh};
		if (q.fsel == `FSEL_AUTO) begin
			exp_now = fe_exponent;
		end else if (q.mask && (q.fsel < `FSEL_AUTO)) begin
			exp_now = 4'h0;
		end else begin
			exp_now = q.fsel;
		end
	end

	// Serial slave, register writes and conversion bookkeeping
	always_comb begin
		d          = q;
		ptr_load   = 1'b0;
		wr_commit  = 1'b0;
		cfg_wr     = 1'b0;
		rd_cfg     = 1'b0;
		conv_start = 1'b0;
		conv_stop  = 1'b0;
		d.sdo      = 1'b0;
		d.scl      = {q.scl[1:0], scl_i};
		d.sda      = {q.sda[1:0], sda_i};
		// register access over the serial pins
		if (stp) begin
			d.st = ST_IDLE;
			d.oe = 1'b0;
		end else if (sta) begin
			d.st   = ST_ADDR;
			d.bits = 4'h0;
			d.oe   = 1'b0;
		end else begin
			unique case (q.st)
				ST_IDLE: begin
					d.oe = 1'b0;
				end
				ST_ADDR, ST_PTR, ST_WR: begin
					if (rise) begin
						d.sh   = {q.sh[6:0], bit_in};
						d.bits = q.bits + 4'h1;
					end
					if (fall && (q.bits == 4'h8)) begin
						d.bits = 4'h0;
						d.oe   = 1'b1;
						if (q.st == ST_ADDR) begin
							d.lo = 1'b0;
							d.rw = q.sh[0];
							d.st = ST_ACK_ADDR;
							if (q.sh[7:1] != DEV_ADDR) begin
								d.st = ST_IDLE;
								d.oe = 1'b0;
							end
						end else if (q.st == ST_PTR) begin
							ptr_load = 1'b1;
							d.ptr    = q.sh;
							d.lo     = 1'b0;
							d.st     = ST_ACK_PTR;
						end else begin
							d.st = ST_ACK_WR;
							d.lo = ~q.lo;
							if (!q.lo) begin
								d.whi = q.sh;
							end else begin
								wr_commit = 1'b1;
							end
						end
					end
				end
				ST_ACK_ADDR: begin
					if (fall) begin
						d.bits = 4'h0;
						if (q.rw) begin
							d.st = ST_RD;
							d.tx = nbyte;
							d.oe = ~nbyte[7];
							d.lo = ~q.lo;
						end else begin
							d.st = ST_PTR;
							d.oe = 1'b0;
						end
					end
				end
				ST_ACK_PTR, ST_ACK_WR: begin
					if (fall) begin
						d.st = ST_WR;
						d.oe = 1'b0;
					end
				end
				ST_RD: begin
					if (fall) begin
						if (q.bits == 4'h7) begin
							d.st   = ST_RACK;
							d.oe   = 1'b0;
							d.bits = 4'h0;
						end else begin
							d.bits = q.bits + 4'h1;
							d.tx   = {q.tx[6:0], 1'b0};
							d.oe   = ~q.tx[6];
						end
					end
				end
				ST_RACK: begin
					if (rise && bit_in) begin
						d.st = ST_IDLE;
					end else if (fall) begin
						d.st = ST_RD;
						d.tx = nbyte;
						d.oe = ~nbyte[7];
						d.lo = ~q.lo;
						rd_cfg = q.lo && (q.ptr == `OFS_CONTROL);
					end
				end
				default: begin
					d.st = ST_IDLE;
					d.oe = 1'b0;
				end
			endcase
		end

		// clear after read, before any set
		if (rd_cfg) begin
			d.ready = 1'b0;
		end

		if (wr_commit) begin
			unique case (q.ptr)
				`OFS_CONTROL: begin
					cfg_wr  = 1'b1;
					d.fsel  = wdat[`CF_FSEL_HI:`CF_FSEL_LO];
					d.clen  = wdat[`CF_CLEN];
					d.mode  = wdat[`CF_MODE_HI:`CF_MODE_LO];
					d.latch = wdat[`CF_LATCH];
					d.sense = wdat[`CF_SENSE];
					d.mask  = wdat[`CF_MASK];
					d.faults = wdat[`CF_FAULT_HI:`CF_FAULT_LO];
					conv_stop  = 1'b1;
					conv_start = (wdat[`CF_MODE_HI:`CF_MODE_LO] != `MODE_OFF);
				end
				`OFS_LOWER: d.lo_lim = wdat;
				`OFS_UPPER: d.hi_lim = wdat;
				default: ;
			endcase
		end

		// Finished conversion lands in the result
		if (conv_done) begin
			d.res[`MAN_HI:`MAN_LO] = fe_mantissa;
			d.res[`EXP_HI:`EXP_LO] = exp_now;
			d.over  = fe_overflow;
			d.ready = 1'b1;
			if (!cfg_wr && (q.mode == `MODE_SINGLE)) begin
				d.mode = `MODE_OFF;
			end
			if (!cfg_wr && q.mode[1]) begin
				conv_start = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q        <= '0;
			q.scl    <= 3'h7;
			q.sda    <= 3'h7;
			q.st     <= ST_IDLE;
			q.fsel   <= CTL_RST[`CF_FSEL_HI:`CF_FSEL_LO];
			q.clen   <= CTL_RST[`CF_CLEN];
			q.mode   <= CTL_RST[`CF_MODE_HI:`CF_MODE_LO];
			q.latch  <= CTL_RST[`CF_LATCH];
			q.sense  <= CTL_RST[`CF_SENSE];
			q.mask   <= CTL_RST[`CF_MASK];
			q.faults <= CTL_RST[`CF_FAULT_HI:`CF_FAULT_LO];
			q.res    <= `RST_RESULT;
			q.lo_lim <= `RST_LIMIT;
			q.hi_lim <= `RST_LIMIT;
		end else begin
			q <= d;
		end
	end

	assign sda_o     = q.sdo;
	assign sda_oe    = q.oe;
	assign range_sel = q.fsel;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	AST_RESULT_RO: assert property (@(posedge clk) disable iff (!rst_b)
		wr_commit && (q.ptr == `OFS_RESULT) && !conv_done |=> $stable(q.res))
		else $error("result changed by a write");

	AST_MANTISSA: assert property (@(posedge clk) disable iff (!rst_b)
		conv_done |=> q.res[`MAN_HI:`MAN_LO] == $past(fe_mantissa))
		else $error("mantissa not captured");

	AST_MASK: assert property (@(posedge clk) disable iff (!rst_b)
		conv_done && q.mask && (q.fsel < `FSEL_AUTO) |=> q.res[`EXP_HI:`EXP_LO] == 4'h0)
		else $error("masked exponent not zero");

	AST_AUTO: assert property (@(posedge clk) disable iff (!rst_b)
		conv_done && (q.fsel == `FSEL_AUTO) |=> q.res[`EXP_HI:`EXP_LO] == $past(fe_exponent))
		else $error("automatic range not reported");

	AST_ABORT: assert property (@(posedge clk) disable iff (!rst_b)
		cfg_wr && (wdat[`CF_MODE_HI:`CF_MODE_LO] == `MODE_OFF) |=> !converting [*2])
		else $error("conversion not aborted");

	AST_RESTART: assert property (@(posedge clk) disable iff (!rst_b)
		cfg_wr && (wdat[`CF_MODE_HI:`CF_MODE_LO] != `MODE_OFF) |=> converting && !conv_done)
		else $error("conversion not restarted");

	AST_PTR_KEEP: assert property (@(posedge clk) disable iff (!rst_b)
		!ptr_load |=> q.ptr == $past(q.ptr))
		else $error("pointer moved without a write");

	AST_READY_CLR: assert property (@(posedge clk) disable iff (!rst_b)
		rd_cfg && !conv_done |=> !q.ready)
		else $error("ready flag not cleared by read");

	AST_SINGLE: assert property (@(posedge clk) disable iff (!rst_b)
		conv_done && !cfg_wr && (q.mode == `MODE_SINGLE) |=> (q.mode == `MODE_OFF) && !converting)
		else $error("single shot did not shut down");
endmodule : ambient_light_register_map

// ==== ambient_light_register_map_tb_top.sv ====
// Self-checking bench for the light sensor register bank
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ambient_light_register_map_tb_top;
	localparam logic [6:0]  ADR = 7'h2a;
	localparam logic [15:0] MKR = 16'h1357; // Arbitrary value
	localparam logic [15:0] PRT = 16'h2468; // Arbitrary value
	logic        clk, rst_b, scl, sda, sda_o, sda_oe, converting, over, ack;
	logic [11:0] man;
	logic [3:0]  fexp, range_sel;
	logic [15:0] d;
	int          miscompares, cmp_count;

	// Free-running clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	ambient_light_register_map #(.DEV_ADDR(ADR), .MAKER_ID(MKR), .PART_ID(PRT),
		.SHORT_CYC(20), .LONG_CYC(50)) i_dut (.clk(clk), .rst_b(rst_b), .scl_i(scl),
		.sda_i(sda), .fe_mantissa(man), .fe_exponent(fexp), .fe_overflow(over),
		.sda_o(sda_o), .sda_oe(sda_oe), .converting(converting), .range_sel(range_sel));
	light_host_model i_host (.clk(clk), .sda_o(sda_o), .sda_oe(sda_oe), .scl(scl),
		.sda(sda));

	////////////////////////////////////////////////////////////////////////////////
	// Point, read and compare
	task automatic rd(input logic [7:0] p, input logic [15:0] e);
		i_host.wr_ptr(ADR, p, ack);
		`CHK(ack, 1'b1)
		i_host.rd(ADR, d, ack);
		`CHK(ack, 1'b1)
		`CHK(d, e)
	endtask : rd

	// Write and expect acknowledge
	task automatic wr(input logic [7:0] p, input logic [15:0] v);
		i_host.wr(ADR, p, v, ack);
		`CHK(ack, 1'b1)
	endtask : wr

	// Bounded wait for conversion end
	task automatic wait_idle;
		for (int i = 0; i < 200 && converting === 1'b1; i++)
			@(negedge clk);
		`CHK(converting, 1'b0)
	endtask : wait_idle

	////////////////////////////////////////////////////////////////////////////////
	// Reset values, identification, unmapped space, control fields
	task automatic t_reset;
		`CHK(range_sel, 4'hc)
		`CHK(converting, 1'b0)
		rd(8'h01, 16'hc810);
		rd(8'h00, 16'h0000);
		rd(8'h02, 16'h0000);
		rd(8'h03, 16'h0000);
		rd(8'h7e, MKR);
		rd(8'h7f, PRT);
		rd(8'h10, 16'h0000);
		wr(8'h7f, 16'h0000);
		rd(8'h7f, PRT);
		// Read-only flag bits and unused bits 6:5 ignore the write, the rest store
		wr(8'h01, 16'h09ff);
		`CHK(range_sel, 4'h0)
		`CHK(converting, 1'b0)
		rd(8'h01, 16'h081f);
		i_host.wr_ptr(7'h2b, 8'h00, ack);
		`CHK(ack, 1'b0)
		$display("t_reset done");
	endtask : t_reset

	// Threshold storage and kept pointer
	task automatic t_limits;
		wr(8'h02, 16'h3456);
		wr(8'h03, 16'hbfff);
		rd(8'h02, 16'h3456);
		rd(8'h03, 16'hbfff);
		i_host.rd(ADR, d, ack);
		`CHK(d, 16'hbfff)
		$display("t_limits done");
	endtask : t_limits

	// Automatic range single shot, ready flag clear
	task automatic t_single;
		man = 12'h89a;
		fexp = 4'h7;
		wr(8'h01, 16'hca00);
		`CHK(converting, 1'b1)
		wait_idle;
		rd(8'h00, 16'h789a);
		rd(8'h01, 16'hc880);
		rd(8'h01, 16'hc800);
		wr(8'h00, 16'h0000);
		rd(8'h00, 16'h789a);
		$display("t_single done");
	endtask : t_single

	// Manual range with and without exponent mask
	task automatic t_mask;
		man = 12'hfff;
		fexp = 4'h9;
		over = 1'b1;
		wr(8'h01, 16'h3204);
		`CHK(range_sel, 4'h3)
		wait_idle;
		rd(8'h00, 16'h0fff);
		rd(8'h01, 16'h3184);
		over = 1'b0;
		wr(8'h01, 16'h3200);
		wait_idle;
		rd(8'h00, 16'h3fff);
		$display("t_mask done");
	endtask : t_mask

	// Continuous runs in both codes, then abort by a control write
	task automatic t_abort;
		man = 12'h123;
		fexp = 4'h2;
		wr(8'h01, 16'hcc00);
		`CHK(converting, 1'b1)
		repeat (120) @(negedge clk);
		rd(8'h00, 16'h2123);
		// Rewrite mid-run: abort, restart with mode code 11
		fexp = 4'h5;
		wr(8'h01, 16'hce00);
		`CHK(converting, 1'b1)
		repeat (120) @(negedge clk);
		rd(8'h01, 16'hce80);
		rd(8'h00, 16'h5123);
		wr(8'h01, 16'hc800);
		`CHK(converting, 1'b0)
		man = 12'hfff;
		repeat (60) @(negedge clk);
		rd(8'h00, 16'h5123);
		$display("t_abort done");
	endtask : t_abort

	////////////////////////////////////////////////////////////////////////////////
	// Counts, verdict and end of run
	task automatic finish_test;
		$display("compares=%0d mismatches=%0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test

	// Main sequence
	initial begin
		rst_b = 1'b0;
		man = 12'h000;
		fexp = 4'h0;
		over = 1'b0;
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		t_reset;
		t_limits;
		t_single;
		t_mask;
		t_abort;
		finish_test;
	end

	// Watchdog against a hung bus
	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		finish_test;
	end
endmodule : ambient_light_register_map_tb_top

// ==== light_conv.sv ====
// Conversion timer: runs one conversion of short or long length
`timescale 1ns/1ps
`include "light_map.svh"
module light_conv #(
	parameter int unsigned SHORT_CYC = `CONV_SHORT_MS * `CLK_KHZ,
	parameter int unsigned LONG_CYC  = `CONV_LONG_MS * `CLK_KHZ
) (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic start,
	input  wire logic stop,
	input  wire logic long_sel,
	output logic      busy,
	output logic      done
);
	localparam int unsigned CW = $clog2(LONG_CYC + 1);

	typedef struct packed {
		logic          busy;
		logic          done;
		logic          lng;
		logic [CW-1:0] cnt;
	} conv_state_t;

	conv_state_t q;
	conv_state_t d;
	logic [CW-1:0] last;

	// Restart wins over abort, abort over counting
	always_comb begin
		d      = q;
		d.done = 1'b0;
		last   = q.lng ? CW'(LONG_CYC - 1) : CW'(SHORT_CYC - 1);
		if (start) begin
			d.busy = 1'b1;
			d.cnt  = '0;
			d.lng  = long_sel;
		end else if (stop) begin
			d.busy = 1'b0;
		end else if (q.busy) begin
			if (q.cnt == last) begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end else begin
				d.cnt = q.cnt + 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign busy = q.busy;
	assign done = q.done;
endmodule : light_conv

// ==== light_host_model.sv ====
// Serial bus host model that reaches the light sensor registers
`timescale 1ns/1ps
module light_host_model (
	input  wire logic clk,
	input  wire logic sda_o,
	input  wire logic sda_oe,
	output logic      scl,
	output wire logic sda
);
	logic drv = 1'b1;

	// Bus idles high after power-up
	initial scl = 1'b1;
	// Open-drain data line with pull-up
	assign sda = drv & ~(sda_oe & ~sda_o);

	////////////////////////////////////////////////////////////////////////////////
	// Wait a number of falling edges
	task automatic hp(input int n);
		repeat (n) @(negedge clk);
	endtask : hp

	// One bit: drive while low, sample while high
	task automatic bit_io(input logic b, output logic r);
		drv = b;
		hp(6);
		scl = 1'b1;
		hp(6);
		r = sda;
		scl = 1'b0;
		hp(2);
	endtask : bit_io

	// Data falls while clock high
	task automatic start;
		drv = 1'b1;
		hp(4);
		scl = 1'b1;
		hp(6);
		drv = 1'b0;
		hp(6);
		scl = 1'b0;
		hp(2);
	endtask : start

	// Data rises while clock high
	task automatic stop;
		drv = 1'b0;
		hp(4);
		scl = 1'b1;
		hp(6);
		drv = 1'b1;
		hp(6);
	endtask : stop

	// Send a byte, MSB first, return the acknowledge
	task automatic put(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(v[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask : put

	// Take a byte, then acknowledge or refuse
	task automatic get(input logic nack, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, v[i]);
		bit_io(nack, r);
	endtask : get

	////////////////////////////////////////////////////////////////////////////////
	// Pointer-only write
	task automatic wr_ptr(input logic [6:0] a, input logic [7:0] p, output logic ack);
		logic k0, k1;
		start;
		put({a, 1'b0}, k0);
		put(p, k1);
		stop;
		ack = k0 & k1;
	endtask : wr_ptr

	// Full register write, high byte first
	task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] v,
		output logic ack);
		logic       k0, k1, k2, k3;
		logic [15:0] w;
		w = v;
		if (p == 8'h01 && w[15:12] > 4'hc)
			w[15:12] = 4'hc;
		start;
		put({a, 1'b0}, k0);
		put(p, k1);
		put(w[15:8], k2);
		put(w[7:0], k3);
		stop;
		ack = k0 & k1 & k2 & k3;
	endtask : wr

	// Register read at the kept pointer
	task automatic rd(input logic [6:0] a, output logic [15:0] d, output logic ack);
		start;
		put({a, 1'b1}, ack);
		get(1'b0, d[15:8]);
		get(1'b1, d[7:0]);
		stop;
	endtask : rd
endmodule : light_host_model

// ==== light_map.svh ====
// Register offsets, field positions, reset values and timing of the light sensor register bank
`ifndef LIGHT_MAP_SVH
`define LIGHT_MAP_SVH
`define OFS_RESULT   8'h00
`define OFS_CONTROL  8'h01
`define OFS_LOWER    8'h02
`define OFS_UPPER    8'h03
`define OFS_MAKER    8'h7e
`define OFS_PART     8'h7f
`define EXP_HI       15
`define EXP_LO       12
`define MAN_HI       11
`define MAN_LO       0
`define CF_FSEL_HI   15
`define CF_FSEL_LO   12
`define CF_CLEN      11
`define CF_MODE_HI   10
`define CF_MODE_LO   9
`define CF_LATCH     4
`define CF_SENSE     3
`define CF_MASK      2
`define CF_FAULT_HI  1
`define CF_FAULT_LO  0
`define RST_CONTROL  16'hc810
`define RST_RESULT   16'h0000
`define RST_LIMIT    16'h0000
`define FSEL_AUTO    4'hc
`define MODE_OFF     2'h0
`define MODE_SINGLE  2'h1
`define CLK_KHZ      50000
`define CONV_SHORT_MS 100
`define CONV_LONG_MS  800
`endif

// ==== light_pkg.sv ====
// Types shared by the light sensor register bank
package light_pkg;
	typedef enum logic [3:0] {
		ST_IDLE     = 4'h0,
		ST_ADDR     = 4'h1,
		ST_ACK_ADDR = 4'h3,
		ST_PTR      = 4'h2,
		ST_ACK_PTR  = 4'h6,
		ST_WR       = 4'h7,
		ST_ACK_WR   = 4'h5,
		ST_RD       = 4'h4,
		ST_RACK     = 4'hc
	} link_state_t;

	typedef struct packed {
		logic [2:0]  scl;
		logic [2:0]  sda;
		link_state_t st;
		logic [3:0]  bits;
		logic [7:0]  sh;
		logic        rw;
		logic        lo;
		logic [7:0]  ptr;
		logic [7:0]  whi;
		logic [7:0]  tx;
		logic        oe;
		logic        sdo;
		logic [3:0]  fsel;
		logic        clen;
		logic [1:0]  mode;
		logic        over;
		logic        ready;
		logic        latch;
		logic        sense;
		logic        mask;
		logic [1:0]  faults;
		logic [15:0] res;
		logic [15:0] lo_lim;
		logic [15:0] hi_lim;
	} bank_state_t;
endpackage : light_pkg
